// ### hdl/ccs_pkg.sv
// Constants, register map and state codes of the charge cycle supervisor.
// Assumes a 250 MHz system clock; all counts derive from it.
package ccs_pkg;
	localparam int unsigned       CNT_W         = 48;
	localparam longint unsigned   CLK_HZ        = 64'd250_000_000;
	// Times in their own units, then derived cycle counts
	localparam longint unsigned   BOOST_DLY_MS  = 64'd40;
	localparam longint unsigned   INT_PULSE_US  = 64'd256;
	localparam longint unsigned   USB_LIMIT_MIN = 64'd45;
	localparam longint unsigned   HOUR_S        = 64'd3600;
	localparam longint unsigned   WD_UNIT_S     = 64'd40;
	localparam logic [CNT_W-1:0]  BOOST_DLY_CYC = CNT_W'(BOOST_DLY_MS * CLK_HZ / 64'd1000);
	localparam logic [CNT_W-1:0]  INT_PULSE_CYC = CNT_W'(INT_PULSE_US * CLK_HZ / 64'd1000000);
	localparam logic [CNT_W-1:0]  USB_LIMIT_CYC = CNT_W'(USB_LIMIT_MIN * 64'd60 * CLK_HZ);
	localparam logic [CNT_W-1:0]  HOUR_CYC      = CNT_W'(HOUR_S * CLK_HZ);
	localparam logic [CNT_W-1:0]  WD_UNIT_CYC   = CNT_W'(WD_UNIT_S * CLK_HZ);
	localparam int unsigned       BLINK_BIT     = 26;
	// Register offsets
	localparam logic [7:0] A_INSRC = 8'h00;
	localparam logic [7:0] A_PONCF = 8'h01;
	localparam logic [7:0] A_ICHG  = 8'h02;
	localparam logic [7:0] A_IPRE  = 8'h03;
	localparam logic [7:0] A_VCHG  = 8'h04;
	localparam logic [7:0] A_TRMTM = 8'h05;
	localparam logic [7:0] A_MISC  = 8'h07;
	localparam logic [7:0] A_STAT  = 8'h08;
	localparam logic [7:0] A_FAULT = 8'h09;
	// Reset values
	localparam logic [7:0] R_INSRC = 8'h32;
	localparam logic [7:0] R_PONCF = 8'h1a;
	localparam logic [7:0] R_ICHG  = 8'h80;
	localparam logic [7:0] R_IPRE  = 8'h11;
	localparam logic [7:0] R_VCHG  = 8'h00;
	localparam logic [7:0] R_TRMTM = 8'h9a;
	localparam logic [7:0] R_MISC  = 8'h40;
	// Field positions
	localparam int unsigned IS_STBY  = 7;
	localparam int unsigned PC_SWRST = 7;
	localparam int unsigned PC_WDKCK = 6;
	localparam int unsigned PC_CFG   = 4;
	localparam int unsigned PC_SMIN  = 1;
	localparam int unsigned IC_FORCE = 0;
	localparam int unsigned VC_RCHG  = 0;
	localparam int unsigned TT_TRMEN = 7;
	localparam int unsigned TT_WD    = 4;
	localparam int unsigned TT_TMREN = 3;
	localparam int unsigned TT_SEL   = 1;
	localparam int unsigned MC_HALF  = 6;
	localparam int unsigned MC_SWOFF = 5;
	// Field codes
	localparam logic [1:0] CFG_OFF   = 2'b00;
	localparam logic [1:0] CFG_CHG   = 2'b01;
	localparam logic [1:0] CFG_BOOST = 2'b10;
	localparam logic [1:0] WD_OFF    = 2'b11;
	localparam logic [1:0] SRC_BOOST = 2'b11;
	localparam logic [1:0] TMR_FLT   = 2'b11;
	// Charge current selection codes
	localparam logic [1:0] CUR_NONE  = 2'b00;
	localparam logic [1:0] CUR_LOW   = 2'b01;
	localparam logic [1:0] CUR_PRE   = 2'b10;
	localparam logic [1:0] CUR_FAST  = 2'b11;
	// Charge phase, coded as reported in the status register
	typedef enum logic [1:0] {
		PH_OFF  = 2'b00,
		PH_PRE  = 2'b01,
		PH_FAST = 2'b10,
		PH_DONE = 2'b11
	} ccs_phase_t;
endpackage : ccs_pkg

// ### hdl/ccs_tmr_if.sv
// Control and status bundle between the supervisor and one interval timer.
// Assumes owner and timer share one clock.
`timescale 1ns/1ps
interface ccs_tmr_if #(parameter int unsigned W = 48);
	logic         clr;
	logic         run;
	logic         half;
	logic [W-1:0] limit;
	logic         expired;
	modport owner (output clr, output run, output half, output limit, input expired);
	modport timer (input clr, input run, input half, input limit, output expired);
endinterface : ccs_tmr_if

// ### hdl/ccs_timer.sv
// Interval timer with optional half-rate counting and a sticky expiry flag.
// Assumes the owner holds clr until a new interval is wanted.
`timescale 1ns/1ps
module ccs_timer #(
	parameter int unsigned W = 48
) (
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	ccs_tmr_if.timer  t
);
	logic [W-1:0] cnt_q;
	logic         ph_q;
	logic         exp_q;

	if (W < 2) begin : g_chk
		$error("ccs_timer: W too small");
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst || t.clr) begin
			cnt_q <= '0;
			ph_q  <= 1'b0;
			exp_q <= 1'b0;
		end else if (t.run && !exp_q) begin
			ph_q <= ~ph_q;
			if (cnt_q >= t.limit) begin
				exp_q <= 1'b1;
			end else if (!t.half || ph_q) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign t.expired = exp_q;
endmodule : ccs_timer

// ### hdl/ccs_supervisor.sv
// Charge cycle supervisor: registers, boost entry, charge phases, timers.
// Assumes analog comparator results arrive synchronous to i_sys_clk.
// Overview of operation
// RULE_01: Boost switching starts 40ms after enable
// RULE_02: Boost active reports source code 11
// RULE_03: Boost fault sets fault bit 6, interrupts
// RULE_04: Minimum system voltage from config bits 3:1
// RULE_05: Status bit 0 shows minimum system regulation
// RULE_06: Input limits exceeded reduce charge current
// RULE_07: Status bit 3 shows dynamic power limiting
// RULE_08: Cycle starts only when all conditions hold
// RULE_09: Terminate when full; recharge below threshold
// RULE_10: State pin low charging, high idle, blinks
// RULE_11: Status bits 5:4 give charge phase
// RULE_12: Start current chosen from battery voltage
// RULE_13: Limiting suspends termination, halves timer
// RULE_14: Thermistor fault reported, interrupts, suspends charge
// RULE_15: Termination: phase 11, interrupt, switch off
// RULE_16: Default mode timer expiry sets standby bit
// RULE_17: Safety timer duration, low battery, fault
// RULE_18: Safety timer restarts on listed events
// RULE_19: Half rate conditions, disable bit
// RULE_20: Default 100mA source capped at 45 minutes
// RULE_21: Default mode after reset, host on write
// RULE_22: Host kicks or disables watchdog in time
// RULE_23: Each interrupt is one 256us low pulse
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ccs_supervisor #(
	parameter logic [47:0]  P_BOOST_CYC   = ccs_pkg::BOOST_DLY_CYC,
	parameter logic [47:0]  P_INT_CYC     = ccs_pkg::INT_PULSE_CYC,
	parameter logic [47:0]  P_USB_CYC     = ccs_pkg::USB_LIMIT_CYC,
	parameter logic [47:0]  P_HOUR_CYC    = ccs_pkg::HOUR_CYC,
	parameter logic [47:0]  P_WD_UNIT_CYC = ccs_pkg::WD_UNIT_CYC,
	parameter int unsigned  P_BLINK_BIT   = ccs_pkg::BLINK_BIT
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_charge_enable_n,
	input  wire logic       i_input_good,
	input  wire logic [1:0] i_src_type,
	input  wire logic       i_src_usb100,
	input  wire logic       i_boost_ready,
	input  wire logic       i_boost_fault,
	input  wire logic       i_bat_below_2v,
	input  wire logic       i_bat_below_3v,
	input  wire logic       i_bat_below_lowbat,
	input  wire logic       i_bat_above_sysmin,
	input  wire logic       i_bat_below_rchg_lo,
	input  wire logic       i_bat_below_rchg_hi,
	input  wire logic       i_chg_below_term,
	input  wire logic       i_in_curr_over,
	input  wire logic       i_in_volt_under,
	input  wire logic       i_thermal_reg,
	input  wire logic       i_sys_min_reg,
	input  wire logic [2:0] i_ts_fault,
	output logic            o_int_n,
	output logic            o_charge_state,
	output logic            o_boost_switch_en,
	output logic            o_buck_en,
	output logic            o_batt_switch_on,
	output logic      [1:0] o_cur_sel,
	output logic            o_dpm_reduce,
	output logic      [6:0] o_input_limits,
	output logic      [2:0] o_sysmin_code
);
	localparam int unsigned TW = ccs_pkg::CNT_W;

	if (P_BLINK_BIT < 1 || P_BLINK_BIT > 40 || P_INT_CYC == 0) begin : g_chk
		$error("ccs_supervisor: unusable parameter value");
	end

	logic [7:0]          insrc_q, poncf_q, ichg_q, ipre_q, vchg_q, trmtm_q, misc_q;
	ccs_pkg::ccs_phase_t ph_q;
	logic                host_q;
	logic                cfg00_q;
	logic                ceb_q;
	logic                ts_any_q;
	logic                boost_on_q;
	logic                boost_flt_q;
	logic                tmr_flt_q;
	logic                safe_flt_q;
	logic                int_act_q;
	logic [P_BLINK_BIT:0] blink_q;

	ccs_tmr_if #(.W(TW)) boost_t ();
	ccs_tmr_if #(.W(TW)) safe_t ();
	ccs_tmr_if #(.W(TW)) usb_t ();
	ccs_tmr_if #(.W(TW)) wd_t ();
	ccs_tmr_if #(.W(TW)) int_t ();

	ccs_timer #(.W(TW)) u_boost (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .t(boost_t));
	ccs_timer #(.W(TW)) u_safe  (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .t(safe_t));
	ccs_timer #(.W(TW)) u_usb   (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .t(usb_t));
	ccs_timer #(.W(TW)) u_wd    (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .t(wd_t));
	ccs_timer #(.W(TW)) u_int   (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .t(int_t));

	// Decoded conditions
	logic       wr_insrc, wr_poncf, wr_trmtm, rd_fault, sw_rst;
	logic [1:0] cfg;
	logic       charging, dynamic_power_limiting, regulating, conv_run, start_ok, rchg_low;
	logic       term_hit, safe_exp_ev, boost_flt_ev, ts_ev, safe_restart;

	assign wr_insrc = i_wr && i_addr == ccs_pkg::A_INSRC;
	assign wr_poncf = i_wr && i_addr == ccs_pkg::A_PONCF;
	assign wr_trmtm = i_wr && i_addr == ccs_pkg::A_TRMTM;
	assign rd_fault = i_rd && i_addr == ccs_pkg::A_FAULT;
	assign sw_rst   = wr_poncf && i_wdata[ccs_pkg::PC_SWRST];
	assign cfg      = poncf_q[ccs_pkg::PC_CFG +: 2];
	assign charging = ph_q == ccs_pkg::PH_PRE || ph_q == ccs_pkg::PH_FAST;
	assign dynamic_power_limiting      = i_in_curr_over || i_in_volt_under;
	assign regulating = dynamic_power_limiting || i_thermal_reg;
	assign conv_run = i_input_good && !insrc_q[ccs_pkg::IS_STBY];
	// Gate for a new charge cycle
	assign start_ok = conv_run && cfg == ccs_pkg::CFG_CHG && !i_charge_enable_n && !safe_flt_q
		&& i_ts_fault == 3'b000 && !misc_q[ccs_pkg::MC_SWOFF]; // RULE_08 RULE_14
	assign rchg_low = vchg_q[ccs_pkg::VC_RCHG] ? i_bat_below_rchg_hi : i_bat_below_rchg_lo; // RULE_09
	assign term_hit = charging && trmtm_q[ccs_pkg::TT_TRMEN] && !regulating
		&& i_chg_below_term && !rchg_low; // RULE_09 RULE_13 RULE_15
	assign safe_exp_ev  = safe_t.expired && !safe_flt_q;
	assign boost_flt_ev = boost_on_q && i_boost_fault && !boost_flt_q;
	assign ts_ev        = i_ts_fault != 3'b000 && !ts_any_q;
	// Restart sources of the safety timer
	assign safe_restart = (start_ok && (ph_q == ccs_pkg::PH_OFF || (ph_q == ccs_pkg::PH_DONE && rchg_low)))
		|| (i_charge_enable_n && !ceb_q)
		|| (wr_poncf && i_wdata[ccs_pkg::PC_CFG +: 2] == ccs_pkg::CFG_CHG && cfg00_q)
		|| (wr_trmtm && i_wdata[ccs_pkg::TT_TMREN] && !trmtm_q[ccs_pkg::TT_TMREN])
		|| sw_rst; // RULE_18

	// Timer wiring
	assign boost_t.clr   = !(cfg == ccs_pkg::CFG_BOOST && i_boost_ready);
	assign boost_t.run   = 1'b1;
	assign boost_t.half  = 1'b0;
	assign boost_t.limit = P_BOOST_CYC; // RULE_01

	assign safe_t.clr   = safe_restart; // RULE_18
	assign safe_t.run   = charging && trmtm_q[ccs_pkg::TT_TMREN]; // RULE_17
	assign safe_t.half  = misc_q[ccs_pkg::MC_HALF] && (regulating
		|| (ichg_q[ccs_pkg::IC_FORCE] && i_bat_above_sysmin)); // RULE_13 RULE_19
	assign safe_t.limit = i_bat_below_lowbat ? P_HOUR_CYC
		: TW'(P_HOUR_CYC * ((TW'(trmtm_q[ccs_pkg::TT_SEL +: 2]) + TW'(1)) << 2)); // RULE_17

	assign usb_t.clr   = host_q || !i_src_usb100;
	assign usb_t.run   = charging;
	assign usb_t.half  = 1'b0;
	assign usb_t.limit = P_USB_CYC; // RULE_20

	assign wd_t.clr   = !host_q || (wr_poncf && i_wdata[ccs_pkg::PC_WDKCK])
		|| trmtm_q[ccs_pkg::TT_WD +: 2] == ccs_pkg::WD_OFF; // RULE_22
	assign wd_t.run   = host_q;
	assign wd_t.half  = 1'b0;
	assign wd_t.limit = P_WD_UNIT_CYC << trmtm_q[ccs_pkg::TT_WD +: 2];

	assign int_t.clr   = !int_act_q;
	assign int_t.run   = int_act_q;
	assign int_t.half  = 1'b0;
	assign int_t.limit = P_INT_CYC; // RULE_23

	// Host writable registers
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || sw_rst) begin
			insrc_q <= ccs_pkg::R_INSRC;
			poncf_q <= ccs_pkg::R_PONCF;
			ichg_q  <= ccs_pkg::R_ICHG;
			ipre_q  <= ccs_pkg::R_IPRE;
			vchg_q  <= ccs_pkg::R_VCHG;
			trmtm_q <= ccs_pkg::R_TRMTM;
			misc_q  <= ccs_pkg::R_MISC;
		end else begin
			if (i_wr) begin
				unique case (i_addr)
					ccs_pkg::A_INSRC: insrc_q <= i_wdata;
					ccs_pkg::A_PONCF: poncf_q <= {2'b00, i_wdata[5:0]};
					ccs_pkg::A_ICHG:  ichg_q  <= i_wdata;
					ccs_pkg::A_IPRE:  ipre_q  <= i_wdata;
					ccs_pkg::A_VCHG:  vchg_q  <= i_wdata;
					ccs_pkg::A_TRMTM: trmtm_q <= i_wdata;
					ccs_pkg::A_MISC:  misc_q  <= i_wdata;
					default: ;
				endcase
			end
			if ((safe_exp_ev && !host_q) || (usb_t.expired && !host_q)) begin
				insrc_q[ccs_pkg::IS_STBY] <= 1'b1; // RULE_16 RULE_20
			end
			if (boost_flt_ev) begin
				poncf_q[ccs_pkg::PC_CFG + 1] <= 1'b0;
			end
		end
	end

	// Mode, watchdog and write history
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			host_q  <= 1'b0;
			cfg00_q <= 1'b0;
			ceb_q   <= 1'b1;
		end else begin
			ceb_q <= i_charge_enable_n;
			if (i_wr) begin
				host_q <= 1'b1; // RULE_21
			end else if (wd_t.expired) begin
				host_q <= 1'b0;
			end
			if (wr_poncf) begin
				cfg00_q <= i_wdata[ccs_pkg::PC_CFG +: 2] == ccs_pkg::CFG_OFF;
			end
		end
	end

	// Charge phase sequencing
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ph_q      <= ccs_pkg::PH_OFF;
			o_cur_sel <= ccs_pkg::CUR_NONE;
		end else begin
			unique case (ph_q)
				ccs_pkg::PH_OFF, ccs_pkg::PH_DONE: begin
					if (!start_ok) begin
						ph_q <= ccs_pkg::PH_OFF;
					end else if (ph_q == ccs_pkg::PH_OFF || rchg_low) begin
						ph_q <= i_bat_below_3v ? ccs_pkg::PH_PRE : ccs_pkg::PH_FAST; // RULE_09 RULE_12
					end
				end
				ccs_pkg::PH_PRE, ccs_pkg::PH_FAST: begin
					if (!start_ok) begin
						ph_q <= ccs_pkg::PH_OFF; // RULE_14
					end else if (term_hit) begin
						ph_q <= ccs_pkg::PH_DONE; // RULE_15
					end else if (ph_q == ccs_pkg::PH_PRE && !i_bat_below_3v) begin
						ph_q <= ccs_pkg::PH_FAST;
					end
				end
			endcase
			if (!charging) begin
				o_cur_sel <= ccs_pkg::CUR_NONE;
			end else if (i_bat_below_2v) begin
				o_cur_sel <= ccs_pkg::CUR_LOW; // RULE_12
			end else if (ph_q == ccs_pkg::PH_PRE) begin
				o_cur_sel <= ccs_pkg::CUR_PRE;
			end else begin
				o_cur_sel <= ccs_pkg::CUR_FAST;
			end
		end
	end

	// Fault latches; a new event wins over a clearing read
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			boost_flt_q <= 1'b0;
			tmr_flt_q   <= 1'b0;
			safe_flt_q  <= 1'b0;
			ts_any_q    <= 1'b0;
		end else begin
			ts_any_q <= i_ts_fault != 3'b000;
			if (boost_on_q && i_boost_fault) begin
				boost_flt_q <= 1'b1; // RULE_03
			end else if (rd_fault) begin
				boost_flt_q <= 1'b0;
			end
			if (safe_exp_ev) begin
				tmr_flt_q <= 1'b1; // RULE_17
			end else if (rd_fault) begin
				tmr_flt_q <= 1'b0;
			end
			if (safe_restart) begin
				safe_flt_q <= 1'b0;
			end else if (safe_exp_ev) begin
				safe_flt_q <= 1'b1;
			end
		end
	end

	// Interrupt pulse
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			int_act_q <= 1'b0;
			o_int_n   <= 1'b1;
		end else begin
			if (!int_act_q && (boost_flt_ev || ts_ev || safe_exp_ev || term_hit)) begin
				int_act_q <= 1'b1; // RULE_03 RULE_14 RULE_15 RULE_17
			end else if (int_t.expired) begin
				int_act_q <= 1'b0; // RULE_23
			end
			o_int_n <= !int_act_q;
		end
	end

	// Power stage controls and indicator
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			boost_on_q        <= 1'b0;
			o_boost_switch_en <= 1'b0;
			o_buck_en         <= 1'b0;
			o_batt_switch_on  <= 1'b0;
			o_dpm_reduce      <= 1'b0;
			o_input_limits    <= 7'h00;
			o_sysmin_code     <= 3'b000;
			o_charge_state    <= 1'b1;
			blink_q           <= '0;
		end else begin
			blink_q           <= blink_q + 1'b1;
			boost_on_q        <= boost_t.expired && !boost_flt_q; // RULE_01
			o_boost_switch_en <= boost_t.expired && !boost_flt_q;
			o_buck_en         <= conv_run; // RULE_16 RULE_20
			o_batt_switch_on  <= !misc_q[ccs_pkg::MC_SWOFF] && ph_q != ccs_pkg::PH_DONE; // RULE_15
			o_dpm_reduce      <= dynamic_power_limiting; // RULE_06
			o_input_limits    <= insrc_q[6:0]; // RULE_06
			o_sysmin_code     <= poncf_q[ccs_pkg::PC_SMIN +: 3]; // RULE_04
			if (safe_flt_q || i_ts_fault != 3'b000) begin
				o_charge_state <= blink_q[P_BLINK_BIT]; // RULE_10
			end else begin
				o_charge_state <= !charging; // RULE_10
			end
		end
	end

	// Read port
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				ccs_pkg::A_INSRC: o_rdata <= insrc_q;
				ccs_pkg::A_PONCF: o_rdata <= poncf_q;
				ccs_pkg::A_ICHG:  o_rdata <= ichg_q;
				ccs_pkg::A_IPRE:  o_rdata <= ipre_q;
				ccs_pkg::A_VCHG:  o_rdata <= vchg_q;
				ccs_pkg::A_TRMTM: o_rdata <= trmtm_q;
				ccs_pkg::A_MISC:  o_rdata <= misc_q;
				ccs_pkg::A_STAT:  o_rdata <= {boost_on_q ? ccs_pkg::SRC_BOOST : i_src_type, ph_q,
					dynamic_power_limiting, i_input_good, i_thermal_reg, i_sys_min_reg}; // RULE_02 RULE_05 RULE_07 RULE_11
				ccs_pkg::A_FAULT: o_rdata <= {!host_q, boost_flt_q, tmr_flt_q ? ccs_pkg::TMR_FLT : 2'b00,
					1'b0, i_ts_fault}; // RULE_03 RULE_14 RULE_21
				default:          o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule : ccs_supervisor

// ### dv/ccs_supervisor_checker.sv
// Port assertions of the charge cycle supervisor.
// Assumes bind parameters match the instance under test.
`timescale 1ns/1ps
module ccs_supervisor_checker #(
	parameter logic [47:0] P_BOOST_CYC = 48'd20
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_boost_ready,
	input  wire logic       i_boost_fault,
	input  wire logic       i_bat_below_3v,
	input  wire logic       i_in_curr_over,
	input  wire logic       i_in_volt_under,
	input  wire logic [2:0] i_ts_fault,
	input  wire logic       o_int_n,
	input  wire logic       o_boost_switch_en,
	input  wire logic [1:0] o_cur_sel,
	input  wire logic       o_dpm_reduce,
	input  wire logic [6:0] o_input_limits,
	input  wire logic [2:0] o_sysmin_code
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic [47:0] rdy_cnt_q;
	always_ff @(posedge i_sys_clk) begin
		rdy_cnt_q <= (i_srst || !i_boost_ready) ? 48'h0 : rdy_cnt_q + 48'h1;
	end
	sequence limit_hit_s;
		(i_in_curr_over || i_in_volt_under) [*2];
	endsequence
	sequence ts_new_s;
		(i_ts_fault != 3'h0) && ($past(i_ts_fault) == 3'h0) && o_int_n;
	endsequence
	boost_delay_a: assert property ($rose(o_boost_switch_en) |-> rdy_cnt_q >= P_BOOST_CYC)
		else $error("boost switching before delay");
	boost_fault_int_a: assert property ($rose(i_boost_fault) && o_int_n |-> ##[1:4] !o_int_n)
		else $error("no interrupt on boost fault");
	sysmin_follow_a: assert property (i_wr && i_addr == ccs_pkg::A_PONCF && !i_wdata[7] |->
		##2 {4'h0, o_sysmin_code, 1'b0} == ($past(i_wdata, 2) & 8'h0e)) else $error("sysmin code wrong");
	dpm_follow_a: assert property (limit_hit_s |-> o_dpm_reduce)
		else $error("no current reduction");
	limits_follow_a: assert property (i_wr && i_addr == ccs_pkg::A_INSRC |->
		##2 {1'b0, o_input_limits} == ($past(i_wdata, 2) & 8'h7f)) else $error("input limits wrong");
	fast_sel_a: assert property (o_cur_sel == ccs_pkg::CUR_FAST && $past(o_cur_sel) != ccs_pkg::CUR_FAST
		|-> !$past(i_bat_below_3v, 2)) else $error("fast current on low battery");
	ts_int_a: assert property (ts_new_s |-> ##[1:4] !o_int_n)
		else $error("no interrupt on thermistor fault");
	int_width_a: assert property ($fell(o_int_n) |-> !o_int_n [*8])
		else $error("interrupt pulse too short");
endmodule : ccs_supervisor_checker

bind ccs_supervisor ccs_supervisor_checker #(.P_BOOST_CYC(P_BOOST_CYC)) ccs_supervisor_checker_inst (
	.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_boost_ready(i_boost_ready), .i_boost_fault(i_boost_fault), .i_bat_below_3v(i_bat_below_3v),
	.i_in_curr_over(i_in_curr_over), .i_in_volt_under(i_in_volt_under), .i_ts_fault(i_ts_fault),
	.o_int_n(o_int_n), .o_boost_switch_en(o_boost_switch_en), .o_cur_sel(o_cur_sel),
	.o_dpm_reduce(o_dpm_reduce), .o_input_limits(o_input_limits), .o_sysmin_code(o_sysmin_code));

// ### dv/ccs_host_model.sv
// Host processor model: master of the register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
module ccs_host_model (
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_rdata,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	initial begin
		o_addr  = 8'h00;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_sys_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_sys_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		@(posedge i_sys_clk);
		d = i_rdata;
	endtask : rd
endmodule : ccs_host_model

// ### dv/charge_cycle_supervisor_tb_top.sv
// Testbench of the charge cycle supervisor with shortened timers.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module charge_cycle_supervisor_tb_top;
	logic i_sys_clk = 1'b0, i_srst = 1'b1, i_charge_enable_n = 1'b1, i_src_usb100 = 1'b0;
	logic i_boost_ready = 1'b0, i_boost_fault = 1'b0, i_bat_below_2v = 1'b0, i_bat_below_3v = 1'b0;
	logic i_bat_below_lowbat = 1'b0, i_bat_below_rchg_lo = 1'b0, i_chg_below_term = 1'b0;
	logic i_in_curr_over = 1'b0, i_in_volt_under = 1'b0, i_sys_min_reg = 1'b0;
	logic [2:0] i_ts_fault = 3'h0;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic i_wr, i_rd, o_int_n, o_charge_state, o_boost_switch_en, o_buck_en, o_batt_switch_on, o_dpm_reduce;
	logic i_input_good = 1'b1, i_bat_above_sysmin = 1'b1, i_bat_below_rchg_hi = 1'b0, i_thermal_reg = 1'b0;
	logic [1:0] o_cur_sel, i_src_type = 2'b01;
	// Shortened timer settings for simulation
	localparam logic [47:0] BOOST_CYC = 48'd20, INT_CYC = 48'd8, USB_CYC = 48'd50, HOUR_CYC = 48'd10;
	localparam logic [47:0] WD_CYC    = 48'd30;
	localparam int unsigned BLINK_BIT = 3;
	logic [6:0] o_input_limits;
	logic [2:0] o_sysmin_code;
	int bad_count = 0, comparisons = 0, n;
	logic [7:0] reg_a [6] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h06, 8'h09};
	logic [7:0] reg_v [6] = '{8'h32, 8'h1a, 8'h9a, 8'h40, 8'h00, 8'h80};
	always #2 i_sys_clk = ~i_sys_clk;
	ccs_supervisor #(.P_BOOST_CYC(BOOST_CYC), .P_INT_CYC(INT_CYC), .P_USB_CYC(USB_CYC), .P_HOUR_CYC(HOUR_CYC),
		.P_WD_UNIT_CYC(WD_CYC), .P_BLINK_BIT(BLINK_BIT)) ccs_supervisor_inst (
		.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_charge_enable_n(i_charge_enable_n), .i_input_good(i_input_good),
		.i_src_type(i_src_type),
		.i_src_usb100(i_src_usb100), .i_boost_ready(i_boost_ready), .i_boost_fault(i_boost_fault),
		.i_bat_below_2v(i_bat_below_2v), .i_bat_below_3v(i_bat_below_3v), .i_bat_below_lowbat(i_bat_below_lowbat),
		.i_bat_above_sysmin(i_bat_above_sysmin), .i_bat_below_rchg_lo(i_bat_below_rchg_lo),
		.i_bat_below_rchg_hi(i_bat_below_rchg_hi),
		.i_chg_below_term(i_chg_below_term), .i_in_curr_over(i_in_curr_over), .i_in_volt_under(i_in_volt_under),
		.i_thermal_reg(i_thermal_reg), .i_sys_min_reg(i_sys_min_reg), .i_ts_fault(i_ts_fault), .o_int_n(o_int_n),
		.o_charge_state(o_charge_state), .o_boost_switch_en(o_boost_switch_en), .o_buck_en(o_buck_en),
		.o_batt_switch_on(o_batt_switch_on), .o_cur_sel(o_cur_sel), .o_dpm_reduce(o_dpm_reduce),
		.o_input_limits(o_input_limits), .o_sysmin_code(o_sysmin_code));
	ccs_host_model ccs_host_model_inst (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		ccs_host_model_inst.rd(a, d);
		chk(d, exp);
	endtask : rchk
	function automatic logic pick(input int w);
		case (w)
			0: return o_int_n;
			1: return o_buck_en;
			2: return o_boost_switch_en;
			default: return o_charge_state;
		endcase
	endfunction : pick
	// Bounded wait for an output level; n holds the cycles spent
	task automatic wait_on(input int w, input logic v, input int lim);
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		chk({7'h0, pick(w)}, {7'h0, v});
		if (pick(w) !== v) test_done();
	endtask : wait_on
	task automatic step(input int c);
		repeat (c) @(posedge i_sys_clk);
		#1;
	endtask : step
	initial begin
		for (int s = 0; s < 3; s++) begin
			@(posedge i_sys_clk);
			i_srst         <= 1'b1;
			i_src_usb100   <= (s != 0);
			i_bat_below_2v <= (s == 1);
			i_bat_below_3v <= (s != 0);
			repeat (4) @(posedge i_sys_clk);
			i_srst <= 1'b0;
			if (s == 0) begin
				foreach (reg_a[i]) rchk(reg_a[i], reg_v[i]);
				rchk(ccs_pkg::A_STAT, 8'h44);
				chk({7'h0, o_charge_state}, 8'h01);
			end
			@(posedge i_sys_clk);
			i_charge_enable_n <= 1'b0;
			step(1);
			wait_on(3, 1'b0, 20);
			chk({6'h0, o_cur_sel}, s == 0 ? 8'h03 : (s == 1 ? 8'h01 : 8'h02));
			rchk(ccs_pkg::A_STAT, s == 0 ? 8'h64 : 8'h54);
			wait_on(1, 1'b0, 200);
			chk({7'h0, n >= (s == 0 ? 70 : 40)}, 8'h01);
			rchk(ccs_pkg::A_INSRC, 8'hb2);
		end
		@(posedge i_sys_clk);
		i_src_usb100   <= 1'b0;
		i_bat_below_3v <= 1'b0;
		ccs_host_model_inst.wr(ccs_pkg::A_TRMTM, 8'hba);
		rchk(ccs_pkg::A_FAULT, 8'h00);
		ccs_host_model_inst.wr(ccs_pkg::A_INSRC, 8'h32);
		step(1);
		wait_on(1, 1'b1, 10);
		wait_on(3, 1'b0, 20);
		chk({6'h0, o_cur_sel}, 8'h03);
		@(posedge i_sys_clk);
		i_in_curr_over   <= 1'b1;
		i_chg_below_term <= 1'b1;
		i_sys_min_reg    <= 1'b1;
		i_thermal_reg    <= 1'b1;
		i_src_type       <= 2'b10;
		step(4);
		chk({7'h0, o_dpm_reduce}, 8'h01);
		rchk(ccs_pkg::A_STAT, 8'haf);
		@(posedge i_sys_clk);
		i_in_curr_over <= 1'b0;
		i_sys_min_reg  <= 1'b0;
		i_src_type     <= 2'b01;
		step(4);
		chk({7'h0, o_int_n}, 8'h01);
		@(posedge i_sys_clk);
		i_thermal_reg <= 1'b0;
		step(1);
		wait_on(0, 1'b0, 20);
		wait_on(0, 1'b1, 40);
		chk({7'h0, n >= 8}, 8'h01);
		chk({5'h0, o_batt_switch_on, o_buck_en, o_charge_state}, 8'h03);
		rchk(ccs_pkg::A_STAT, 8'h74);
		@(posedge i_sys_clk);
		i_chg_below_term    <= 1'b0;
		i_bat_below_rchg_lo <= 1'b1;
		step(1);
		wait_on(3, 1'b0, 20);
		@(posedge i_sys_clk);
		i_bat_below_rchg_lo <= 1'b0;
		i_ts_fault          <= 3'h2;
		step(1);
		wait_on(0, 1'b0, 20);
		rchk(ccs_pkg::A_FAULT, 8'h02);
		wait_on(3, ~o_charge_state, 40);
		wait_on(3, ~o_charge_state, 40);
		@(posedge i_sys_clk);
		i_ts_fault <= 3'h0;
		step(8);
		rchk(ccs_pkg::A_STAT, 8'h64);
		ccs_host_model_inst.wr(ccs_pkg::A_TRMTM, 8'hb2);
		i_bat_below_lowbat <= 1'b1;
		i_in_volt_under    <= 1'b1;
		ccs_host_model_inst.wr(ccs_pkg::A_TRMTM, 8'hba);
		step(12);
		rchk(ccs_pkg::A_FAULT, 8'h00);
		i_in_volt_under <= 1'b0;
		step(30);
		rchk(ccs_pkg::A_FAULT, 8'h30);
		wait_on(3, ~o_charge_state, 40);
		@(posedge i_sys_clk);
		i_boost_ready <= 1'b1;
		ccs_host_model_inst.wr(ccs_pkg::A_PONCF, 8'h2a);
		step(14);
		chk({4'h0, o_sysmin_code, o_boost_switch_en}, 8'h0a);
		wait_on(2, 1'b1, 20);
		rchk(ccs_pkg::A_STAT, 8'hc4);
		i_boost_fault <= 1'b1;
		step(1);
		wait_on(0, 1'b0, 20);
		rchk(ccs_pkg::A_FAULT, 8'h40);
		i_input_good <= 1'b0;
		step(2);
		chk({7'h0, o_buck_en}, 8'h00);
		test_done();
	end
endmodule : charge_cycle_supervisor_tb_top
